// ==== hw/adc_params.svh ====
// register map, field positions, reset values and timing counts of the
// converter sequencer; assumes a 32-bit classic bus with one word per register
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define ADC_IDX_ABORT      4'h0
`define ADC_IDX_RESERVED   4'h1
`define ADC_IDX_POWER_IRQ  4'h2
`define ADC_IDX_FREEZE     4'h3
`define ADC_IDX_TIMING     4'h4
`define ADC_IDX_SEQ_START  4'h5
`define ADC_IDX_STATUS     4'h6
`define ADC_IDX_TEST       4'h7
`define ADC_IDX_RESULT_MSB 3

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ADC_PWR_POWER_UP   7
`define ADC_PWR_FAST_CLEAR 6
`define ADC_PWR_WAIT_STOP  5
`define ADC_PWR_IRQ_EN     1
`define ADC_PWR_IRQ_FLAG   0
`define ADC_STAT_SEQ_DONE  15

// ------------------------------------------------------------
// reset values and freeze codes
// ------------------------------------------------------------
`define ADC_RST_BYTE       8'h00
`define ADC_RST_PRESCALE   5'h01
`define ADC_FREEZE_NOW     2'h3
`define ADC_FREEZE_AFTER   2'h2

// ------------------------------------------------------------
// timing counts in converter clock periods
// ------------------------------------------------------------
`define ADC_CONV_BASE_8B   6'h10
`define ADC_CONV_BASE_10B  6'h12
`define ADC_SAMPLE_2       6'h02
`define ADC_SAMPLE_4       6'h04
`define ADC_SAMPLE_8       6'h08
`define ADC_SAMPLE_16      6'h10

`endif

// ==== hw/adc_pkg.sv ====
// types shared by the converter sequencer files
// assumes adc_params.svh supplies the numeric constants
package adc_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'h0,
		SEQ_START   = 2'h1,
		SEQ_CONVERT = 2'h3
	} seq_state_e;

	typedef struct packed {
		logic       resolution_select;
		logic [1:0] sample_time;
		logic [4:0] prescale_field;
	} timing_cfg_s;

	typedef struct packed {
		logic       reserved_bit;
		logic       eight_channel_select;
		logic       scan_mode;
		logic       multichannel_mode;
		logic [3:0] channel_select;
	} seq_cfg_s;

endpackage

// ==== hw/adc_prescaler.sv ====
// converter clock enable from the peripheral clock
// assumes the caller holds run_in low while the converter is powered down
`timescale 1ns/100ps
`include "adc_params.svh"

module adc_prescaler (
	input  wire logic       sys_clk_in,
	input  wire logic       nrst_in,
	input  wire logic       run_in,
	input  wire logic [4:0] prescale_in,
	output logic            tick_out
);
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	wire  [5:0] limit = {prescale_in, 1'b1};
	// compare with >= so that lowering the prescale mid-count cannot leave
	// the counter above its new limit and skip a whole wrap of 64 clocks
	wire        at_limit = (cnt_q >= limit);

	// one tick per 2*(prescale+1) clocks; stays in one clock domain
	assign tick_out = run_in & at_limit;
	assign cnt_d    = (!run_in || at_limit) ? 6'h00 : cnt_q + 6'h01;

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in)
			cnt_q <= 6'h00;
		else
			cnt_q <= cnt_d;
	end
endmodule

// ==== hw/adc_conv_timer.sv ====
// times one conversion in converter clock periods
// assumes tick_in is already gated by freeze and wait conditions
`timescale 1ns/100ps
`include "adc_params.svh"

module adc_conv_timer (
	input  wire logic                sys_clk_in,
	input  wire logic                nrst_in,
	input  wire logic                start_in,
	input  wire logic                abort_in,
	input  wire logic                tick_in,
	input  wire adc_pkg::timing_cfg_s cfg_in,
	output logic                     busy_out,
	output logic                     sampling_out,
	output logic                     done_out
);
	logic [5:0] cnt_q;
	logic       busy_q;
	logic       done_q;
	logic [5:0] sample_len;
	logic [5:0] total_len;

	function automatic logic [5:0] sample_periods(input logic [1:0] sel);
		case (sel)
			2'h0:    sample_periods = `ADC_SAMPLE_2;
			2'h1:    sample_periods = `ADC_SAMPLE_4;
			2'h2:    sample_periods = `ADC_SAMPLE_8;
			default: sample_periods = `ADC_SAMPLE_16;
		endcase
	endfunction

	assign sample_len   = sample_periods(cfg_in.sample_time);
	assign total_len    = sample_len + (cfg_in.resolution_select ?
	                      `ADC_CONV_BASE_10B : `ADC_CONV_BASE_8B);
	wire   last_tick    = busy_q & tick_in & (cnt_q == total_len - 6'h01);
	assign busy_out     = busy_q;
	assign done_out     = done_q;
	assign sampling_out = busy_q & (cnt_q < sample_len);

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in || abort_in) begin
			busy_q <= 1'b0;
			cnt_q  <= 6'h00;
			done_q <= 1'b0;
		end else begin
			done_q <= last_tick;
			if (start_in) begin
				busy_q <= 1'b1;
				cnt_q  <= 6'h00;
			end else if (last_tick) begin
				busy_q <= 1'b0;
			end else if (busy_q && tick_in) begin
				cnt_q <= cnt_q + 6'h01;
			end
		end
	end
endmodule

// ==== hw/adc_sequencer_control.sv ====
// converter sequencer: registers, sequence control, flags and timing
// assumes a classic single-cycle bus master and a converter core whose
// result is valid when the conversion timer finishes
`timescale 1ns/100ps
`include "adc_params.svh"

module adc_sequencer_control (
	input  wire logic        sys_clk_in,
	input  wire logic        nrst_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [5:2]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic [31:0]      wb_dat_out,
	output logic             wb_ack_out,
	input  wire logic        special_mode_in,
	input  wire logic        wait_mode_in,
	input  wire logic        debug_active_in,
	input  wire logic [9:0]  conv_result_in,
	output logic             analog_power_out,
	output logic             converter_clk_en_out,
	output logic             conv_start_out,
	output logic             sampling_out,
	output logic [3:0]       channel_out,
	output logic             seq_irq_out
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
		end else begin
			pin_meta_q <= {special_mode_in, wait_mode_in, debug_active_in};
			pin_sync_q <= pin_meta_q;
		end
	end

	wire special_mode = pin_sync_q[2];
	wire wait_mode    = pin_sync_q[1];
	wire debug_active = pin_sync_q[0];

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic                ack_q;
	logic [31:0]         rdat_q;
	logic [15:0]         rdata;
	logic [7:0]          abort_ctl_q;
	logic [7:0]          power_ctl_q;
	logic [1:0]          freeze_q;
	adc_pkg::timing_cfg_s timing_q;
	adc_pkg::seq_cfg_s   seq_cfg_q;
	logic                seq_done_q;
	logic [7:0]          ccf_q;
	logic [7:0]          ccf_armed_q;
	logic [2:0]          conv_idx_q;
	logic [9:0]          result_q [8];

	wire access   = wb_cyc_in & wb_stb_in & ~ack_q;
	wire wr_low   = access & wb_we_in & wb_sel_in[0];
	wire rd       = access & ~wb_we_in;
	wire is_result = wb_adr_in[5];
	wire [2:0] res_idx = wb_adr_in[4:2];

	function automatic logic hit(input logic [3:0] adr, input logic [3:0] idx);
		hit = (adr == idx);
	endfunction

	wire wr_abort   = wr_low & hit(wb_adr_in, `ADC_IDX_ABORT);
	wire wr_power   = wr_low & hit(wb_adr_in, `ADC_IDX_POWER_IRQ);
	wire wr_freeze  = wr_low & hit(wb_adr_in, `ADC_IDX_FREEZE);
	wire wr_timing  = wr_low & hit(wb_adr_in, `ADC_IDX_TIMING);
	wire wr_start   = wr_low & hit(wb_adr_in, `ADC_IDX_SEQ_START);
	wire rd_status  = rd & hit(wb_adr_in, `ADC_IDX_STATUS);
	wire rd_result  = rd & is_result;
	wire any_result = access & is_result;

	always_comb begin
		rdata = 16'h0000;
		case (wb_adr_in)
			`ADC_IDX_ABORT:     rdata = {8'h00, abort_ctl_q};
			`ADC_IDX_RESERVED:  rdata = 16'h0000;
			`ADC_IDX_POWER_IRQ: rdata = {8'h00, power_ctl_q[7:1], seq_done_q};
			`ADC_IDX_FREEZE:    rdata = {14'h0000, freeze_q};
			`ADC_IDX_TIMING:    rdata = {8'h00, timing_q};
			`ADC_IDX_SEQ_START: rdata = {8'h00, seq_cfg_q};
			`ADC_IDX_STATUS:    rdata = {seq_done_q, 4'h0, conv_idx_q, ccf_q};
			`ADC_IDX_TEST:      rdata = 16'h0000;
			default:            rdata = {6'h00, result_q[res_idx]};
		endcase
	end

	// one-cycle registered answer, each 16-bit register in the low half
	assign wb_ack_out = ack_q;
	assign wb_dat_out = rdat_q;

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= access;
			rdat_q <= access ? {16'h0000, rdata} : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			abort_ctl_q <= `ADC_RST_BYTE;
			power_ctl_q <= `ADC_RST_BYTE;
			freeze_q    <= 2'h0;
			timing_q    <= '{1'b0, 2'h0, `ADC_RST_PRESCALE};
			seq_cfg_q   <= `ADC_RST_BYTE;
		end else begin
			if (wr_abort)
				abort_ctl_q <= wb_dat_in[7:0];
			if (wr_power)
				power_ctl_q <= {wb_dat_in[7:1], 1'b0};
			if (wr_freeze)
				freeze_q <= wb_dat_in[1:0];
			if (wr_timing)
				timing_q <= wb_dat_in[7:0];
			if (wr_start)
				seq_cfg_q <= wb_dat_in[7:0];
		end
	end

	wire powered    = power_ctl_q[`ADC_PWR_POWER_UP];
	wire fast_clear = power_ctl_q[`ADC_PWR_FAST_CLEAR];
	wire wait_stop  = power_ctl_q[`ADC_PWR_WAIT_STOP];
	wire irq_enable = power_ctl_q[`ADC_PWR_IRQ_EN];

	// ------------------------------------------------------------
	// hold conditions and converter clock
	// ------------------------------------------------------------
	// a write to any of these control registers aborts; a timing write
	// leaves the sequencer idle until the next start write
	wire abort = wr_abort | wr_power | wr_freeze | wr_timing
	           | ~powered;
	wire wait_halt    = wait_stop & wait_mode;
	// freeze code 01 is reserved and runs like 00
	wire freeze_now   = debug_active & (freeze_q == `ADC_FREEZE_NOW);
	wire freeze_after = debug_active & (freeze_q == `ADC_FREEZE_AFTER);
	wire hold_clock   = freeze_now | wait_halt;
	wire hold_start   = hold_clock | freeze_after;
	wire ps_tick;
	wire busy;
	wire conv_done;
	logic start_pulse;

	adc_prescaler u_prescaler (
		.sys_clk_in  (sys_clk_in),
		.nrst_in     (nrst_in),
		.run_in      (powered),
		.prescale_in (timing_q.prescale_field),
		.tick_out    (ps_tick)
	);

	wire conv_tick = ps_tick & ~hold_clock;

	adc_conv_timer u_timer (
		.sys_clk_in   (sys_clk_in),
		.nrst_in      (nrst_in),
		.start_in     (start_pulse),
		.abort_in     (abort | wr_start),
		.tick_in      (conv_tick),
		.cfg_in       (timing_q),
		.busy_out     (busy),
		.sampling_out (sampling_out),
		.done_out     (conv_done)
	);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	adc_pkg::seq_state_e state_q;
	adc_pkg::seq_state_e state_d;
	logic                eight_q;
	logic                first_seq_q;
	logic [3:0]          channel_q;

	wire [2:0] last_idx = eight_q ? 3'h7 : 3'h3;
	wire       seq_end  = conv_done & (conv_idx_q == last_idx);
	wire       scan     = seq_cfg_q.scan_mode;
	// group size is latched from the start write itself, so a sequence
	// never changes length halfway through

	// multichannel walks the group, the low bits follow the counter
	function automatic logic [3:0] pick_channel(
		input adc_pkg::seq_cfg_s cfg, input logic eight, input logic [2:0] n);
		if (!cfg.multichannel_mode)
			pick_channel = cfg.channel_select;
		else if (eight)
			pick_channel = {cfg.channel_select[3], n};
		else
			pick_channel = {cfg.channel_select[3:2], n[1:0]};
	endfunction

	always_comb begin
		state_d     = state_q;
		start_pulse = 1'b0;
		case (state_q)
			adc_pkg::SEQ_IDLE: state_d = adc_pkg::SEQ_IDLE;
			adc_pkg::SEQ_START: begin
				if (!hold_start) begin
					start_pulse = 1'b1;
					state_d     = adc_pkg::SEQ_CONVERT;
				end
			end
			adc_pkg::SEQ_CONVERT: begin
				if (seq_end && !scan)
					state_d = adc_pkg::SEQ_IDLE;
				else if (conv_done)
					state_d = adc_pkg::SEQ_START;
			end
			default: state_d = adc_pkg::SEQ_IDLE;
		endcase
		if (wr_start)
			state_d = adc_pkg::SEQ_START;
		if (abort)
			state_d = adc_pkg::SEQ_IDLE;
	end

	assign conv_start_out = start_pulse;

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			state_q     <= adc_pkg::SEQ_IDLE;
			conv_idx_q  <= 3'h0;
			eight_q     <= 1'b0;
			first_seq_q <= 1'b0;
			channel_q   <= 4'h0;
		end else begin
			state_q <= state_d;
			if (wr_start) begin
				conv_idx_q  <= 3'h0;
				eight_q     <= wb_dat_in[6];
				first_seq_q <= 1'b1;
			end else if (abort) begin
				conv_idx_q <= 3'h0;
			end else if (conv_done) begin
				conv_idx_q <= seq_end ? 3'h0 : conv_idx_q + 3'h1;
				if (seq_end)
					first_seq_q <= 1'b0;
			end
			if (start_pulse)
				channel_q <= pick_channel(seq_cfg_q, eight_q, conv_idx_q);
		end
	end

	assign channel_out          = channel_q;
	assign analog_power_out     = powered;
	assign converter_clk_en_out = conv_tick;

	// ------------------------------------------------------------
	// results and flags
	// ------------------------------------------------------------
	wire       load_result = conv_done & (state_q == adc_pkg::SEQ_CONVERT);
	wire [9:0] conv_value  = timing_q.resolution_select ? conv_result_in
	                       : {2'h0, conv_result_in[9:2]};

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_result
			wire sel_me = (res_idx == 3'(g));
			wire set_me = load_result & (conv_idx_q == 3'(g));
			wire clr_me = fast_clear ? (any_result & sel_me)
			            : (rd_result & sel_me & ccf_armed_q[g]);
			always_ff @(posedge sys_clk_in) begin
				if (!nrst_in) begin
					result_q[g]    <= 10'h000;
					ccf_q[g]       <= 1'b0;
					ccf_armed_q[g] <= 1'b0;
				end else begin
					if (set_me)
						result_q[g] <= conv_value;
					// a load in the clearing cycle keeps its flag
					if (set_me)
						ccf_q[g] <= 1'b1;
					else if (clr_me || wr_start)
						ccf_q[g] <= 1'b0;
					if (rd_status)
						ccf_armed_q[g] <= ccf_q[g] & ~set_me;
					else if (clr_me || set_me || wr_start)
						ccf_armed_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// sequence done doubles as the irq flag; it is never written by software
	wire scf_set = seq_end & first_seq_q & (state_q == adc_pkg::SEQ_CONVERT);
	wire scf_clr = wr_start | (fast_clear & rd_result);

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in)
			seq_done_q <= 1'b0;
		else if (scf_set)
			seq_done_q <= 1'b1;
		else if (scf_clr)
			seq_done_q <= 1'b0;
	end

	assign seq_irq_out = seq_done_q & irq_enable;

	// reserved register reads zero in every mode, special mode or not,
	// so the mode pin only matters for future test bits
	wire unused_special = special_mode;
	wire unused_abort   = |abort_ctl_q & unused_special & busy;
endmodule

// ==== tb/adc_core_model.sv ====
// behavioural model of the analog multiplexer and converter core
// assumes the sequencer samples the result only when a conversion ends
`timescale 1ns/100ps

module adc_core_model (
	input  wire logic       sys_clk_in,
	input  wire logic       power_in,
	input  wire logic [3:0] channel_in,
	output logic      [9:0] result_out
);
	logic [9:0] last_q = 10'h2aa;

	// unpowered core output is meaningless, so it toggles every cycle
	always_ff @(posedge sys_clk_in) begin
		if (power_in) begin
			last_q <= {channel_in, 6'h15};
		end else begin
			last_q <= ~last_q;
		end
	end

	assign result_out = last_q;
endmodule

// ==== tb/adc_seq_chk.sv ====
// port checker for the converter sequencer
// assumes it is bound to adc_sequencer_control by the statement below
`timescale 1ns/100ps

module adc_seq_chk (
	input wire logic        sys_clk_in,
	input wire logic        nrst_in,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_we_in,
	input wire logic [5:2]  wb_adr_in,
	input wire logic [3:0]  wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic        wb_ack_out,
	input wire logic        analog_power_out,
	input wire logic        converter_clk_en_out,
	input wire logic        conv_start_out,
	input wire logic        seq_irq_out
);
	// ----------------------------------------------------------
	// request decode and properties
	// ----------------------------------------------------------
	wire logic req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	wire logic wr  = req & wb_we_in & wb_sel_in[0];
	wire logic rd  = req & ~wb_we_in;

	default clocking dc @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_no_start;
		!conv_start_out [*3];
	endsequence
	sequence s_rd_zero;
		wb_ack_out && wb_dat_out == 32'h0000_0000;
	endsequence

	chk_ack_next: assert property (req |=> wb_ack_out)
		else $error("ack missing after request");
	chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	chk_upper_zero: assert property (
		wb_ack_out |-> wb_dat_out[31:16] == 16'h0000)
		else $error("upper read data not zero");
	chk_rsvd_zero: assert property (
		rd && (wb_adr_in == 4'h1 || wb_adr_in == 4'h7) |=> s_rd_zero)
		else $error("reserved register read not zero");
	chk_power_bit: assert property (
		wr && wb_adr_in == 4'h2
		|=> analog_power_out == $past(wb_dat_in[7]))
		else $error("power output does not follow write");
	chk_power_off: assert property (
		!analog_power_out ##1 !analog_power_out
		|-> !converter_clk_en_out && !conv_start_out)
		else $error("activity while powered down");
	chk_abort_gap: assert property (
		wr && wb_adr_in inside {4'h0, 4'h2, 4'h3, 4'h4} |=> s_no_start)
		else $error("conversion started after abort");
	chk_irq_mask: assert property (
		wr && wb_adr_in == 4'h2 && !wb_dat_in[1] |=> !seq_irq_out)
		else $error("irq with enable cleared");
	chk_start_clear: assert property (
		wr && wb_adr_in == 4'h5 |=> !seq_irq_out)
		else $error("irq not cleared by start");
	chk_start_go: assert property (
		wr && wb_adr_in == 4'h5 && analog_power_out
		|-> ##[1:3] conv_start_out)
		else $error("no conversion after start");
	chk_tick_gap: assert property (
		converter_clk_en_out |=> !converter_clk_en_out)
		else $error("converter tick on adjacent cycles");
endmodule

bind adc_sequencer_control adc_seq_chk u_chk (
	.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
	.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.analog_power_out(analog_power_out),
	.converter_clk_en_out(converter_clk_en_out),
	.conv_start_out(conv_start_out), .seq_irq_out(seq_irq_out));

// ==== tb/adc_sequencer_control_tb.sv ====
// self-checking bench for the converter sequencer
// assumes the core model and the bound checker are compiled first
`timescale 1ns/100ps

module adc_sequencer_control_tb;
	// ----------------------------------------------------------
	// bench state and wiring
	// ----------------------------------------------------------
	logic        clk, nrst, cyc, stb, we, wait_m, dbg;
	logic [3:0]  adr, chan;
	logic [31:0] wdat, rdat;
	logic [9:0]  res;
	logic        ack, pwr, tick, start, samp, irq;
	int          fail_count, tests_run, cycles, starts, ticks, i, p, sticks;
	int          tq[$];

	adc_sequencer_control u_dut (
		.sys_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .special_mode_in(1'b0),
		.wait_mode_in(wait_m), .debug_active_in(dbg),
		.conv_result_in(res), .analog_power_out(pwr),
		.converter_clk_en_out(tick), .conv_start_out(start),
		.sampling_out(samp), .channel_out(chan), .seq_irq_out(irq));
	adc_core_model u_core (.sys_clk_in(clk), .power_in(pwr),
		.channel_in(chan), .result_out(res));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (start === 1'b1) begin
			starts++;
			tq.push_back(ticks);
		end
		if (tick === 1'b1) ticks++;
		if (tick === 1'b1 && samp === 1'b1) sticks++;
		if (cycles == 60000) begin
			fail_count++;
			complete_run();
		end
	end

	// ----------------------------------------------------------
	// bus, compare and measurement tasks
	// ----------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic bus(input logic [3:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		if (n == 50) fail_count++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		check(e, q);
	endtask

	// counters are cleared off the edge so the monitor never races them
	task automatic quiet(input int n);
		@(negedge clk);
		ticks = 0;
		starts = 0;
		repeat (n) @(negedge clk);
	endtask

	task automatic period(output int c);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tick !== 1'b1 && n < 200);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (tick !== 1'b1 && c < 200);
	endtask

	task automatic wait_done();
		logic [31:0] q;
		int n;
		q = 32'h0;
		n = 0;
		while (q[15] !== 1'b1 && n < 600) begin
			bus(4'h6, 1'b0, 32'h0, q);
			n++;
		end
		if (q[15] !== 1'b1) fail_count++;
	endtask

	// multichannel single sequence against a queue of expected results
	task automatic run_seq(input logic r, input logic [1:0] smp,
		input logic e8, input logic [7:0] pw);
		logic [3:0]  ch, c;
		logic [31:0] s;
		logic [31:0] q[$];
		int          n, k, t;
		ch = 4'($urandom());
		n = e8 ? 8 : 4;
		t = (r ? 18 : 16) + (2 << smp);
		for (k = 0; k < n; k++) begin
			c = e8 ? {ch[3], 3'(k)} : {ch[3:2], 2'(k)};
			q.push_back(r ? {22'h0, c, 6'h15} : {24'h0, c, 4'h5});
		end
		wr(4'h4, {24'h0, r, smp, 5'h01});
		wr(4'h2, {24'h0, pw});
		@(negedge clk);
		starts = 0;
		sticks = 0;
		tq.delete();
		wr(4'h5, {25'h0, e8, 2'b01, ch});
		wait_done();
		check(pw[1], irq);
		check(n, starts);
		check(n * (2 << smp), sticks);
		for (k = 1; k < n; k++)
			check(1, unsigned'(tq[k] - tq[k-1] - t) < 2);
		quiet(200);
		check(0, starts);
		bus(4'h6, 1'b0, 32'h0, s);
		check({1'b1, e8 ? 8'hff : 8'h0f}, {s[15], s[7:0]});
		for (k = 0; k < n; k++) rd(4'(8 + k), q.pop_front());
		bus(4'h6, 1'b0, 32'h0, s);
		check({~pw[6], 8'h00}, {s[15], s[7:0]});
		$display("sequence test done");
	endtask

	// ----------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------
	initial begin
		{nrst, cyc, stb, we, wait_m, dbg} = 6'h00;
		adr = 4'h0;
		wdat = 32'h0;
		void'($urandom(32'ha584_ac94));
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		for (i = 0; i < 8; i++) rd(4'(i), 32'(i == 4));
		wr(4'h1, 32'h0000_00ff);
		wr(4'h7, 32'h0000_00ff);
		wr(4'h6, 32'h0000_ffff);
		rd(4'h1, 32'h0);
		rd(4'h7, 32'h0);
		rd(4'h6, 32'h0);
		wr(4'h2, 32'h0000_0083);
		rd(4'h2, 32'h0000_0082);
		wr(4'h0, 32'h0000_005a);
		rd(4'h0, 32'h0000_005a);
		$display("register test done");
		period(p);
		check(4, p);
		for (i = 0; i < 4; i++) begin
			wr(4'h4, 32'(i));
			period(p);
			check(2 * (i + 1), p);
		end
		$display("prescaler test done");
		for (i = 0; i < 4; i++) run_seq(1'($urandom()), 2'(i), 1'(i), 8'h82);
		run_seq(1'b1, 2'h3, 1'b1, 8'hc0);
		for (i = 0; i < 4; i++) begin
			wr(4'h2, 32'h0000_0080);
			wr(4'h5, 32'h0000_0030);
			wr(4'(i == 0 ? 0 : i + 1), i == 1 ? 32'h80 : 32'(i == 3));
			quiet(300);
			check(0, starts);
		end
		wr(4'h5, 32'h0000_0030);
		wait_done();
		quiet(300);
		check(1, starts > 2);
		$display("abort and scan test done");
		for (i = 0; i < 4; i++) begin
			wr(4'h3, 32'(i));
			wr(4'h5, 32'h0000_0030);
			dbg <= 1'b1;
			repeat (4) @(posedge clk);
			quiet(300);
			check(i < 2, starts > 0);
			check(i == 3, ticks == 0);
			@(posedge clk);
			dbg <= 1'b0;
		end
		wr(4'h3, 32'h0);
		wr(4'h0, 32'h0);
		for (i = 0; i < 2; i++) begin
			wr(4'h2, i ? 32'h0000_00a0 : 32'h0000_0080);
			wait_m <= 1'b1;
			repeat (4) @(posedge clk);
			quiet(100);
			check(i ? 0 : 25, ticks);
			@(posedge clk);
			wait_m <= 1'b0;
		end
		$display("freeze and wait test done");
		wr(4'h2, 32'h0000_0080);
		wr(4'h5, 32'h0000_0030);
		wr(4'h2, 32'h0);
		quiet(100);
		check(0, ticks + starts);
		check(0, pwr);
		$display("power test done");
		complete_run();
	end
endmodule
